//--- rtl/uepa_consts.vh
`ifndef UEPA_CONSTS_VH
`define UEPA_CONSTS_VH

// Register addresses on the plain register port.
`define UEPA_ADDR_FUNC_ADDR 32'h50001800
`define UEPA_ADDR_EP0_CTRL 32'h50001840
`define UEPA_ADDR_EP0_TXDATA 32'h50001842
`define UEPA_ADDR_EP0_TXSTAT 32'h50001844
`define UEPA_ADDR_EP0_TXCMD 32'h50001846

// Function address register fields.
`define UEPA_FAR_ENABLE_BIT 7
`define UEPA_FAR_RESET 8'h00

// Endpoint 0 control register fields.
`define UEPA_CTRL_STALL_BIT 7
`define UEPA_CTRL_DEFAULT_BIT 6
`define UEPA_CTRL_RESET 2'h0

// Transmit command register fields.
`define UEPA_CMD_IGNORE_IN_BIT 4
`define UEPA_CMD_FLUSH_BIT 3
`define UEPA_CMD_TOGGLE_BIT 2
`define UEPA_CMD_ENABLE_BIT 0

// Transmit status register fields.
`define UEPA_STAT_ACK_BIT 6
`define UEPA_STAT_DONE_BIT 5

// Transmit FIFO and link.
`define UEPA_FIFO_DEPTH 4'h8
`define UEPA_LINK_WIDTH 9
`define UEPA_PID_DATA0 8'hc3
`define UEPA_PID_DATA1 8'h4b
`define UEPA_PID_STALL 8'h1e
`define UEPA_CRC_INIT 16'hffff
`define UEPA_CRC_POLY 16'ha001
`define UEPA_DEFAULT_ADDR 7'h00
`define UEPA_EP0_NUMBER 4'h0

`endif

//--- rtl/uepa_link_buffer.v
`include "uepa_consts.vh"
`default_nettype none

// Two-entry buffer between the packet sequencer and the link serializer.
module uepa_link_buffer (
    // Clock and reset
    input wire clock,
    input wire reset,
    // Filling side
    input wire inValid,
    input wire [`UEPA_LINK_WIDTH-1:0] inData,
    output wire inReady,
    // Draining side
    output wire outValid,
    output wire [`UEPA_LINK_WIDTH-1:0] outData,
    input wire outReady
);
    reg [`UEPA_LINK_WIDTH-1:0] entry0;
    reg [`UEPA_LINK_WIDTH-1:0] entry1;
    reg [1:0] fill;
    reg readPtr;
    reg writePtr;
    wire push;
    wire pop;

    assign inReady = (fill != 2'h2);
    assign outValid = (fill != 2'h0);
    assign outData = readPtr ? entry1 : entry0;
    assign push = inValid && inReady;
    assign pop = outValid && outReady;

    always @(posedge clock) begin
        if (reset) begin
            entry0 <= {`UEPA_LINK_WIDTH{1'b0}};
            entry1 <= {`UEPA_LINK_WIDTH{1'b0}};
            fill <= 2'h0;
            readPtr <= 1'b0;
            writePtr <= 1'b0;
        end else begin
            if (push && !writePtr) begin
                entry0 <= inData;
            end
            if (push && writePtr) begin
                entry1 <= inData;
            end
            if (push) begin
                writePtr <= ~writePtr;
            end
            if (pop) begin
                readPtr <= ~readPtr;
            end
            if (push && !pop) begin
                fill <= fill + 2'h1;
            end else if (pop && !push) begin
                fill <= fill - 2'h1;
            end
        end
    end
endmodule

`default_nettype wire

//--- rtl/uepa_ep0_tx.v
// Operation
// - With default select set, answer address zero on endpoint zero, regardless of the function address field.
// - Hardware clears default select once an IN data packet is sent.
// - The assigned address is not used while the address transfer is running.
// - The assigned address matches right after the address transfer finishes.
// - The endpoint number field reads zero; writes to it are ignored.
// - Hardware generates the packet identifier and CRC16 around the payload.
// - Transmit enable with an empty FIFO sends a packet without payload.
// - The reported free count never exceeds eight bytes.
`include "uepa_consts.vh"
`default_nettype none

module uepa_ep0_tx (
    // Clock and reset
    input wire clock,
    input wire reset,
    // Register port
    input wire [31:0] regAddr,
    input wire [15:0] regWriteData,
    input wire regWrite,
    input wire regRead,
    output reg [15:0] regReadData,
    // Token decoder
    input wire usbBusReset,
    input wire inToken,
    input wire [6:0] tokenAddress,
    input wire [3:0] tokenEndpoint,
    input wire hostAck,
    // Link serializer
    output wire linkValid,
    output wire [7:0] linkByte,
    output wire linkLast,
    input wire linkReady,
    // Status toward the controller
    output wire addressMatch,
    output wire [6:0] functionAddress
);
    localparam ST_IDLE = 3'h0;
    localparam ST_PID = 3'h1;
    localparam ST_DATA = 3'h2;
    localparam ST_CRCLO = 3'h3;
    localparam ST_CRCHI = 3'h4;
    localparam ST_STALL = 3'h5;

    reg [7:0] functionAddressRegister;
    reg stallBit;
    reg defaultAddrFlag;
    reg txEnable;
    reg toggleBit;
    reg ignoreIn;
    reg flushPending;
    reg txDone;
    reg ackStatus;
    reg [7:0] fifoMem [0:7];
    reg [2:0] fifoWrPtr;
    reg [2:0] fifoRdPtr;
    reg [3:0] fifoCount;
    reg [2:0] state;
    reg [15:0] crc;
    reg pushValid;
    reg [7:0] pushByte;
    reg pushLast;
    wire pushReady;
    wire [`UEPA_LINK_WIDTH-1:0] linkWord;
    wire wrCtrl;
    wire wrData;
    wire wrCmd;
    wire rdStat;
    wire fifoWrite;
    wire fifoPop;
    wire startTx;
    wire packetEnd;
    wire [4:0] freeCount;

    // Byte-wise USB CRC16, reflected polynomial, least significant bit first.
    function [15:0] crcStep;
        input [15:0] crcIn;
        input [7:0] dataIn;
        integer i;
        reg [15:0] c;
        begin
            c = crcIn;
            for (i = 0; i < 8; i = i + 1) begin
                c = (c[0] ^ dataIn[i]) ? ((c >> 1) ^ `UEPA_CRC_POLY) : (c >> 1);
            end
            crcStep = c;
        end
    endfunction

    assign wrCtrl = regWrite && (regAddr == `UEPA_ADDR_EP0_CTRL);
    assign wrData = regWrite && (regAddr == `UEPA_ADDR_EP0_TXDATA);
    assign wrCmd = regWrite && (regAddr == `UEPA_ADDR_EP0_TXCMD);
    assign rdStat = regRead && (regAddr == `UEPA_ADDR_EP0_TXSTAT);
    assign functionAddress = functionAddressRegister[6:0];

    // While the default flag stands only address zero answers, so the address
    // transfer finishes on the old address; its IN packet drops the flag.
    assign addressMatch = (tokenEndpoint == `UEPA_EP0_NUMBER) &&
        (defaultAddrFlag ? (tokenAddress == `UEPA_DEFAULT_ADDR) :
        (functionAddressRegister[`UEPA_FAR_ENABLE_BIT] &&
        (tokenAddress == functionAddressRegister[6:0])));

    assign startTx = (state == ST_IDLE) && inToken && addressMatch && txEnable && !ignoreIn;
    assign packetEnd = pushReady && ((state == ST_CRCHI) || (state == ST_STALL));
    // Bytes arriving into a full FIFO are dropped; firmware must watch the free count.
    // A bus reset may empty the FIFO under a running packet, so popping stops at zero.
    assign fifoWrite = wrData && (fifoCount != `UEPA_FIFO_DEPTH);
    assign fifoPop = (state == ST_DATA) && pushReady && (fifoCount != 4'h0);
    assign freeCount = {1'b0, `UEPA_FIFO_DEPTH - fifoCount};

    always @* begin
        pushValid = 1'b0;
        pushByte = 8'h00;
        pushLast = 1'b0;
        case (state)
            ST_PID: begin
                pushValid = 1'b1;
                pushByte = toggleBit ? `UEPA_PID_DATA1 : `UEPA_PID_DATA0;
            end
            ST_DATA: begin
                pushValid = 1'b1;
                pushByte = fifoMem[fifoRdPtr];
            end
            ST_CRCLO: begin
                pushValid = 1'b1;
                pushByte = ~crc[7:0];
            end
            ST_CRCHI: begin
                pushValid = 1'b1;
                pushByte = ~crc[15:8];
                pushLast = 1'b1;
            end
            ST_STALL: begin
                pushValid = 1'b1;
                pushByte = `UEPA_PID_STALL;
                pushLast = 1'b1;
            end
            default: pushValid = 1'b0;
        endcase
    end

    always @(posedge clock) begin
        if (reset) begin
            state <= ST_IDLE;
            crc <= `UEPA_CRC_INIT;
        end else begin
            case (state)
                ST_IDLE: begin
                    if (startTx) begin
                        state <= stallBit ? ST_STALL : ST_PID;
                    end
                    crc <= `UEPA_CRC_INIT;
                end
                ST_PID: begin
                    if (pushReady) begin
                        // An empty FIFO goes straight to the CRC: zero-length packet.
                        state <= (fifoCount == 4'h0) ? ST_CRCLO : ST_DATA;
                    end
                end
                ST_DATA: begin
                    if (pushReady) begin
                        crc <= crcStep(crc, pushByte);
                        if (fifoCount <= 4'h1 && !fifoWrite) begin
                            state <= ST_CRCLO;
                        end
                    end
                end
                ST_CRCLO: begin
                    if (pushReady) begin
                        state <= ST_CRCHI;
                    end
                end
                ST_CRCHI, ST_STALL: begin
                    if (pushReady) begin
                        state <= ST_IDLE;
                    end
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    // FIFO pointers; a flush waits until the running packet has left.
    always @(posedge clock) begin
        if (reset || usbBusReset || (flushPending && state == ST_IDLE)) begin
            fifoWrPtr <= 3'h0;
            fifoRdPtr <= 3'h0;
            fifoCount <= 4'h0;
            flushPending <= 1'b0;
        end else begin
            if (wrCmd && regWriteData[`UEPA_CMD_FLUSH_BIT]) begin
                flushPending <= 1'b1;
            end
            if (fifoWrite) begin
                fifoWrPtr <= fifoWrPtr + 3'h1;
            end
            if (fifoPop) begin
                fifoRdPtr <= fifoRdPtr + 3'h1;
            end
            if (fifoWrite && !fifoPop) begin
                fifoCount <= fifoCount + 4'h1;
            end else if (fifoPop && !fifoWrite) begin
                fifoCount <= fifoCount - 4'h1;
            end
        end
    end
    genvar g;
    generate
        for (g = 0; g < 8; g = g + 1) begin : fifoEntry
            localparam [2:0] ENTRY_INDEX = g;
            always @(posedge clock) begin
                if (reset) begin
                    fifoMem[g] <= 8'h00;
                end else if (fifoWrite && fifoWrPtr == ENTRY_INDEX) begin
                    fifoMem[g] <= regWriteData[7:0];
                end
            end
        end
    endgenerate

    // Control and status registers; hardware sets win over software clears.
    always @(posedge clock) begin
        if (reset || usbBusReset) begin
            functionAddressRegister <= `UEPA_FAR_RESET;
            stallBit <= 1'b0;
            defaultAddrFlag <= 1'b0;
            txEnable <= 1'b0;
            toggleBit <= 1'b0;
            ignoreIn <= 1'b0;
            txDone <= 1'b0;
            ackStatus <= 1'b0;
        end else begin
            if (regWrite && regAddr == `UEPA_ADDR_FUNC_ADDR) begin
                functionAddressRegister <= regWriteData[7:0];
            end
            if (wrCtrl) begin
                stallBit <= regWriteData[`UEPA_CTRL_STALL_BIT];
                defaultAddrFlag <= regWriteData[`UEPA_CTRL_DEFAULT_BIT];
            end
            if (wrCmd) begin
                txEnable <= regWriteData[`UEPA_CMD_ENABLE_BIT];
                toggleBit <= regWriteData[`UEPA_CMD_TOGGLE_BIT];
                ignoreIn <= regWriteData[`UEPA_CMD_IGNORE_IN_BIT];
            end
            if (rdStat) begin
                txDone <= 1'b0;
                ackStatus <= 1'b0;
            end
            if (hostAck) begin
                ackStatus <= 1'b1;
            end
            if (packetEnd) begin
                txEnable <= 1'b0;
                txDone <= 1'b1;
            end
            if (pushReady && state == ST_CRCHI) begin
                defaultAddrFlag <= 1'b0;
            end
        end
    end

    // Read data stand in the cycle after the read strobe.
    always @(posedge clock) begin
        if (reset) begin
            regReadData <= 16'h0000;
        end else if (regRead) begin
            case (regAddr)
                `UEPA_ADDR_FUNC_ADDR: regReadData <= {8'h00, functionAddressRegister};
                `UEPA_ADDR_EP0_CTRL: regReadData <= {8'h00, stallBit, defaultAddrFlag,
                    6'h00};
                `UEPA_ADDR_EP0_TXSTAT: regReadData <= {9'h000, ackStatus, txDone, freeCount};
                `UEPA_ADDR_EP0_TXCMD: regReadData <= {11'h000, ignoreIn, 1'b0, toggleBit,
                    1'b0, txEnable};
                default: regReadData <= 16'h0000;
            endcase
        end else begin
            regReadData <= 16'h0000;
        end
    end

    uepa_link_buffer linkBuffer (
        .clock(clock),
        .reset(reset),
        .inValid(pushValid),
        .inData({pushLast, pushByte}),
        .inReady(pushReady),
        .outValid(linkValid),
        .outData(linkWord),
        .outReady(linkReady)
    );

    assign linkByte = linkWord[7:0];
    assign linkLast = linkWord[8];
endmodule

`default_nettype wire

//--- testbench/uepa_ep0_checker.sv
`include "uepa_consts.vh"
`default_nettype none
module uepa_ep0_checker (
    // Clock and reset
    input wire logic clock,
    input wire logic reset,
    // Register port
    input wire logic [31:0] regAddr,
    input wire logic regRead,
    input wire logic [15:0] regReadData,
    // Token and link
    input wire logic inToken,
    input wire logic [6:0] tokenAddress,
    input wire logic [3:0] tokenEndpoint,
    input wire logic linkValid,
    input wire logic [7:0] linkByte,
    input wire logic linkLast,
    input wire logic linkReady,
    input wire logic addressMatch,
    input wire logic [6:0] functionAddress
);
    timeunit 1ns;
    timeprecision 1ps;
    logic headPending;
    always @(posedge clock) begin
        if (reset) begin
            headPending <= 1'b1;
        end else if (linkValid && linkReady) begin
            headPending <= linkLast;
        end
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);
    a_endpoint_gate: assert property (tokenEndpoint != 4'h0 |-> !addressMatch)
        else $error("match on nonzero endpoint");
    a_assigned_match: assert property (addressMatch && tokenAddress != 7'h00
        |-> tokenAddress == functionAddress) else $error("match on wrong address");
    a_epfield_zero: assert property ($past(regRead)
        && $past(regAddr) == `UEPA_ADDR_EP0_CTRL |-> regReadData[3:0] == 4'h0)
        else $error("endpoint field not zero");
    a_free_bound: assert property ($past(regRead)
        && $past(regAddr) == `UEPA_ADDR_EP0_TXSTAT |-> regReadData[4:0] <= 5'h08)
        else $error("free count above eight");
    a_head_pid: assert property (linkValid && headPending
        |-> linkByte inside {8'hc3, 8'h4b, 8'h1e}) else $error("packet head not a pid");
    a_stall_alone: assert property (linkValid && headPending
        |-> linkLast == (linkByte == 8'h1e)) else $error("wrong packet framing");
    a_hold_offer: assert property (linkValid && !linkReady
        |=> linkValid && $stable(linkByte) && $stable(linkLast)) else $error("offer dropped");
    a_answer_token: assert property ($rose(linkValid) && headPending
        |-> $past(inToken && addressMatch, 2)) else $error("packet without token");
endmodule
bind uepa_ep0_tx uepa_ep0_checker uepa_ep0_checker_inst (.clock(clock), .reset(reset),
    .regAddr(regAddr), .regRead(regRead), .regReadData(regReadData), .inToken(inToken),
    .tokenAddress(tokenAddress), .tokenEndpoint(tokenEndpoint), .linkValid(linkValid),
    .linkByte(linkByte), .linkLast(linkLast), .linkReady(linkReady),
    .addressMatch(addressMatch), .functionAddress(functionAddress));
`default_nettype wire

//--- testbench/uepa_link_host.sv
`default_nettype none
module uepa_link_host (
    // Clock and reset
    input wire logic clock,
    input wire logic reset,
    // Serializer side
    input wire logic linkValid,
    input wire logic linkLast,
    output logic linkReady,
    output logic hostAck,
    // Pace
    input wire logic slow
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] pace;
    // A slow host stalls on a pseudo-random pattern so that the buffer must hold words.
    always @(posedge clock) begin
        if (reset) begin
            pace <= 8'h5a;
            linkReady <= 1'b0;
            hostAck <= 1'b0;
        end else begin
            pace <= {pace[6:0], pace[7] ^ pace[5] ^ pace[4] ^ pace[3]};
            linkReady <= slow ? pace[0] : 1'b1;
            hostAck <= linkValid && linkReady && linkLast;
        end
    end
endmodule
`default_nettype wire

//--- testbench/usb_ep0_address_and_tx_data_tb.sv
`include "uepa_consts.vh"
`default_nettype none
module usb_ep0_address_and_tx_data_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [31:0] farA = `UEPA_ADDR_FUNC_ADDR;
    localparam logic [31:0] ctlA = `UEPA_ADDR_EP0_CTRL;
    localparam logic [31:0] datA = `UEPA_ADDR_EP0_TXDATA;
    localparam logic [31:0] staA = `UEPA_ADDR_EP0_TXSTAT;
    localparam logic [31:0] cmdA = `UEPA_ADDR_EP0_TXCMD;
    logic clock = 1'b0;
    logic reset = 1'b1;
    logic [31:0] regAddr = 32'h0;
    logic [15:0] regWriteData = 16'h0;
    logic regWrite = 1'b0;
    logic regRead = 1'b0;
    logic usbBusReset = 1'b0;
    logic inToken = 1'b0;
    logic [6:0] tokenAddress = 7'h0;
    logic [3:0] tokenEndpoint = 4'h0;
    logic slow = 1'b0;
    logic [15:0] regReadData;
    logic hostAck, linkValid, linkLast, linkReady, addressMatch;
    logic [7:0] linkByte;
    logic [6:0] functionAddress;
    int error_cnt = 0;
    int checked = 0;
    logic [31:0] rnd = 32'hc6ef;
    logic [7:0] expQ[$];
    logic [7:0] pay[$];
    logic [6:0] addr;
    always #10 clock = ~clock;
    uepa_ep0_tx uepa_ep0_tx_inst (.clock(clock), .reset(reset), .regAddr(regAddr),
        .regWriteData(regWriteData), .regWrite(regWrite), .regRead(regRead),
        .regReadData(regReadData), .usbBusReset(usbBusReset), .inToken(inToken),
        .tokenAddress(tokenAddress), .tokenEndpoint(tokenEndpoint), .hostAck(hostAck),
        .linkValid(linkValid), .linkByte(linkByte), .linkLast(linkLast),
        .linkReady(linkReady), .addressMatch(addressMatch), .functionAddress(functionAddress));
    uepa_link_host uepa_link_host_inst (.clock(clock), .reset(reset), .linkValid(linkValid),
        .linkLast(linkLast), .linkReady(linkReady), .hostAck(hostAck), .slow(slow));
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [31:0] a, input logic [15:0] d);
        @(posedge clock);
        regAddr <= a;
        regWriteData <= d;
        regWrite <= 1'b1;
        @(posedge clock);
        regWrite <= 1'b0;
    endtask
    task automatic rd(input logic [31:0] a, input logic [15:0] e);
        @(posedge clock);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge clock);
        regRead <= 1'b0;
        #1 check(regReadData, e);
    endtask
    task automatic mt(input logic [6:0] a, input logic [3:0] ep, input logic e);
        @(posedge clock);
        tokenAddress <= a;
        tokenEndpoint <= ep;
        #1 check({15'h0, addressMatch}, {15'h0, e});
    endtask
    task automatic expect_pkt(input logic [7:0] pid);
        logic [15:0] crc;
        crc = `UEPA_CRC_INIT;
        expQ.push_back(pid);
        foreach (pay[i]) begin
            expQ.push_back(pay[i]);
            crc ^= {8'h0, pay[i]};
            repeat (8) crc = crc[0] ? (crc >> 1) ^ `UEPA_CRC_POLY : crc >> 1;
        end
        if (pid != 8'h1e) begin
            expQ.push_back(~crc[7:0]);
            expQ.push_back(~crc[15:8]);
        end
        pay.delete();
    endtask
    task automatic token(input logic [6:0] a);
        int n;
        @(posedge clock);
        tokenAddress <= a;
        tokenEndpoint <= 4'h0;
        inToken <= 1'b1;
        @(posedge clock);
        inToken <= 1'b0;
        for (n = 0; n < 200 && expQ.size() != 0; n++) @(posedge clock);
        check(16'(expQ.size()), 16'h0);
        repeat (4) @(posedge clock);
    endtask
    // Every byte the host takes is held against the bench's own packet model.
    always @(posedge clock) begin
        if (!reset && linkValid && linkReady) begin
            if (expQ.size() == 0) begin
                check({8'h0, linkByte}, 16'hffff);
            end else begin
                check({8'h0, linkByte}, {8'h0, expQ[0]});
                check({15'h0, linkLast}, {15'h0, expQ.size() == 1});
                void'(expQ.pop_front());
            end
        end
    end
    task automatic give_verdict;
        if (error_cnt == 0 && checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    initial begin
        repeat (4000) @(posedge clock);
        error_cnt++;
        give_verdict;
    end
    initial begin
        repeat (5) @(posedge clock);
        reset <= 1'b0;
        rd(ctlA, 16'h0000);
        rd(staA, 16'h0008);
        rd(32'h50001850, 16'h0000);
        wr(ctlA, 16'hffff);
        rd(ctlA, 16'h00c0);
        wr(farA, 16'h0080);
        wr(ctlA, 16'h0000);
        rnd = xs(rnd);
        addr = rnd[6:0] | 7'h01;
        wr(ctlA, 16'h0040);
        wr(farA, {8'h0, 1'b1, addr});
        mt(7'h00, 4'h0, 1'b1);
        mt(addr, 4'h0, 1'b0);
        mt(7'h00, 4'h5, 1'b0);
        wr(cmdA, 16'h0005);
        expect_pkt(`UEPA_PID_DATA1);
        token(7'h00);
        rd(staA, 16'h0068);
        rd(ctlA, 16'h0000);
        mt(addr, 4'h0, 1'b1);
        check({9'h0, functionAddress}, {9'h0, addr});
        mt(7'h00, 4'h0, 1'b0);
        for (int i = 0; i < 9; i++) begin
            rnd = xs(rnd);
            if (i < 8) pay.push_back(rnd[7:0]);
            wr(datA, {8'h0, rnd[7:0]});
        end
        rd(staA, 16'h0000);
        rd(datA, 16'h0000);
        slow <= 1'b1;
        wr(cmdA, 16'h0001);
        expect_pkt(`UEPA_PID_DATA0);
        token(addr);
        rd(staA, 16'h0068);
        wr(cmdA, 16'h0001);
        token(addr ^ 7'h01);
        expect_pkt(`UEPA_PID_DATA0);
        token(addr);
        wr(ctlA, 16'h0080);
        wr(cmdA, 16'h0001);
        expect_pkt(`UEPA_PID_STALL);
        token(addr);
        // A flush empties the FIFO again; done and ack of the stall stay up.
        wr(datA, {8'h0, rnd[15:8]});
        wr(cmdA, 16'h0008);
        rd(staA, 16'h0068);
        // With ignore set an enabled endpoint sends nothing and keeps its enable.
        wr(cmdA, 16'h0011);
        token(addr);
        rd(cmdA, 16'h0011);
        @(posedge clock);
        usbBusReset <= 1'b1;
        @(posedge clock);
        usbBusReset <= 1'b0;
        rd(farA, 16'h0000);
        check({9'h0, functionAddress}, 16'h0000);
        give_verdict;
    end
endmodule
`default_nettype wire
